// ===== hw/bfr_pkg.sv
// Package: constants for the boot flash concurrent-read access controller
package bfr_pkg;

    // ************************************************************
    // Register map (byte addresses on APB)
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_LOCK   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h10;
    localparam logic [7:0] ADDR_TADDR  = 8'h14;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_BUSY_CLR   = 0;  // Write one: clear region busy flag
    localparam int CTRL_LOCK_WR    = 1;  // Write one: program lock bits from data [5:2]
    localparam int CTRL_CHIP_ERASE = 8;  // Write one: restore lock bits to unprogrammed
    localparam int ST_BUSY         = 0;
    localparam int ST_PROG         = 1;
    localparam int ST_STALL        = 2;
    localparam int IRQ_DONE        = 0;
    localparam int IRQ_DENIED      = 1;
    localparam int IRQ_W           = 2;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [1:0]  LOCK_RESET   = 2'h3;
    localparam logic [2:0]  BOOT_SZ_DEF  = 3'h0;
    localparam int          CLK_MHZ      = 100;
    localparam int          PROG_TIME_US = 4;
    localparam int          PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

endpackage

// ===== hw/bfr_ctrl.sv
// Module: access control and stall logic for self-programming of program flash
//
// Notes on behaviour
// RULE_01: Store-to-program only starts from boot section.
// RULE_02: Boot section store may target any page.
// RULE_03: Boot boundary set by fuses only.
// RULE_04: Fixed split: concurrent-read and stalling regions.
// RULE_05: Concurrent-region programming: core runs, stalling reads.
// RULE_06: Stalling-region programming halts core throughout.
// RULE_07: Busy flag high while concurrent region blocked.
// RULE_08: Software clears busy before reading that region.
// RULE_09: Software avoids concurrent region during programming.
// RULE_10: Software disables or relocates interrupts meanwhile.
// RULE_11: Boot section lies wholly in stalling region.
// RULE_12: Two independent lock sets, application and boot.
// RULE_13: Application lock encoding gates stores and loads.
// RULE_14: Boot lock encoding mirrors application encoding.
// RULE_15: Target address latched when programming starts.
// RULE_16: Lock bits return to one only by erase.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
module bfr_ctrl
    import bfr_pkg::*;
#(
    parameter int AW          = 13,            // Word address width
    parameter int CONC_END    = 13'h1c00,      // First stalling-region word
    parameter int PROG_CYC    = PROG_CYCLES
)(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Fuses (static straps)
    input  wire logic [2:0]    boot_size_fuses,
    // Core store/load requests
    input  wire logic          store_to_program_op,
    input  wire logic          load_from_program_op,
    input  wire logic [AW-1:0] pc_addr,
    input  wire logic [AW-1:0] target_addr,
    // Core control outputs
    output logic               core_halt,
    output logic               load_allowed,
    output logic               prog_start,
    output logic [AW-1:0]      prog_addr,
    output logic               region_busy_flag,
    // APB
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Interrupt
    output logic               irq
);

    // ************************************************************
    // Fuse capture and partition decode
    // ************************************************************
    logic [2:0]    fuse_sync1_reg;
    logic [2:0]    fuse_sync2_reg;
    logic [2:0]    fuse_reg;
    logic [1:0]    fuse_cnt_reg;
    logic [AW-1:0] boot_start;
    logic          pc_in_boot;
    logic          tgt_in_boot;
    logic          tgt_in_conc;

    // Fuses are sampled after reset release only; logic cannot alter them later
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fuse_sync1_reg <= BOOT_SZ_DEF;
            fuse_sync2_reg <= BOOT_SZ_DEF;
            fuse_reg       <= BOOT_SZ_DEF;
            fuse_cnt_reg   <= 2'h0;
        end
        else
        begin
            fuse_sync1_reg <= boot_size_fuses;
            fuse_sync2_reg <= fuse_sync1_reg;
            if (fuse_cnt_reg != 2'h3)
            begin
                fuse_cnt_reg <= fuse_cnt_reg + 2'h1;
                fuse_reg     <= fuse_sync2_reg;  // RULE_03
            end
        end
    end

    // Boot size shrinks as the fuse code rises; the largest starts at the region boundary
    always_comb
    begin
        case (fuse_reg[1:0])
            2'h0:    boot_start = AW'(CONC_END);  // RULE_11
            2'h1:    boot_start = AW'((2 ** AW) - 512);
            2'h2:    boot_start = AW'((2 ** AW) - 256);
            default: boot_start = AW'((2 ** AW) - 128);
        endcase
    end

    assign pc_in_boot  = pc_addr >= boot_start;
    assign tgt_in_boot = target_addr >= boot_start;
    assign tgt_in_conc = target_addr < AW'(CONC_END);  // RULE_04

    // ************************************************************
    // Lock bits
    // ************************************************************
    logic [1:0] app_lock_reg;   // {app_lock_upper, app_lock_lower}
    logic [1:0] boot_lock_reg;  // {boot_lock_upper, boot_lock_lower}
    logic       store_blocked;
    logic       load_blocked;
    logic       wr_en;
    logic       rd_en;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            app_lock_reg  <= LOCK_RESET;
            boot_lock_reg <= LOCK_RESET;
        end
        else if (wr_en && paddr == ADDR_CTRL && pwdata[CTRL_CHIP_ERASE])
        begin
            app_lock_reg  <= LOCK_RESET;  // RULE_16
            boot_lock_reg <= LOCK_RESET;
        end
        else if (wr_en && paddr == ADDR_CTRL && pwdata[CTRL_LOCK_WR])
        begin
            // Bits may only be programmed to zero here
            app_lock_reg  <= app_lock_reg & pwdata[3:2];   // RULE_12 RULE_16
            boot_lock_reg <= boot_lock_reg & pwdata[5:4];  // RULE_12
        end
    end

    // Store blocked when the lower lock bit of the target section is programmed (10 and 00)
    assign store_blocked = tgt_in_boot ? !boot_lock_reg[0] : !app_lock_reg[0];  // RULE_13 RULE_14
    // Cross-section loads blocked when the upper lock bit is programmed (00 and 01)
    assign load_blocked  = (pc_in_boot && !tgt_in_boot && !app_lock_reg[1] )
                        || (!pc_in_boot && tgt_in_boot && !boot_lock_reg[1]);  // RULE_13 RULE_14

    // ************************************************************
    // Programming sequencer
    // ************************************************************
    typedef enum logic [1:0] {BFR_IDLE, BFR_PROG_CONC, BFR_PROG_STALL} bfr_state_e;
    bfr_state_e  state_reg;
    logic [15:0] cnt_reg;
    logic        start_ok;
    logic        done;
    logic        denied;

    assign start_ok = store_to_program_op && pc_in_boot && !store_blocked
                   && state_reg == BFR_IDLE;  // RULE_01 RULE_02
    assign denied   = store_to_program_op && state_reg == BFR_IDLE && !start_ok;
    assign done     = state_reg != BFR_IDLE && cnt_reg == 16'h0001;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= BFR_IDLE;
            cnt_reg   <= 16'h0000;
            prog_addr <= '0;
        end
        else
        begin
            case (state_reg)
                BFR_IDLE:
                begin
                    if (start_ok)
                    begin
                        prog_addr <= target_addr;  // RULE_15
                        cnt_reg   <= 16'(PROG_CYC);
                        state_reg <= tgt_in_conc ? BFR_PROG_CONC : BFR_PROG_STALL;
                    end
                end
                BFR_PROG_CONC, BFR_PROG_STALL:
                begin
                    cnt_reg <= cnt_reg - 16'h0001;
                    if (done)
                        state_reg <= BFR_IDLE;
                end
                default: state_reg <= BFR_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Core-facing outputs
    // ************************************************************
    logic busy_set;
    assign busy_set = start_ok && tgt_in_conc;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_halt        <= 1'b0;
            prog_start       <= 1'b0;
            load_allowed     <= 1'b0;
            region_busy_flag <= 1'b0;
        end
        else
        begin
            prog_start <= start_ok;
            // Halt for the whole operation on the stalling region
            core_halt  <= (start_ok && !tgt_in_conc)
                       || (state_reg == BFR_PROG_STALL && !done);  // RULE_06
            // Reads into concurrent region refused while it is blocked
            load_allowed <= load_from_program_op && !load_blocked
                         && !(region_busy_flag && target_addr < AW'(CONC_END));  // RULE_05 RULE_09
            // Set wins over a software clear in the same cycle
            if (busy_set)
                region_busy_flag <= 1'b1;  // RULE_07
            else if (wr_en && paddr == ADDR_CTRL && pwdata[CTRL_BUSY_CLR] && state_reg != BFR_PROG_CONC)
                region_busy_flag <= 1'b0;  // RULE_08
        end
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    logic [IRQ_W-1:0] irq_st_reg;
    logic [IRQ_W-1:0] irq_mk_reg;
    logic [IRQ_W-1:0] irq_ev;

    assign irq_ev = {denied, done};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_st_reg <= '0;
            irq_mk_reg <= '0;
            irq        <= 1'b0;
        end
        else
        begin
            // Clear only what the read returned, so an event during the read is kept
            if (rd_en && paddr == ADDR_IRQ_ST)
                irq_st_reg <= (irq_st_reg & ~prdata[IRQ_W-1:0]) | irq_ev;
            else
                irq_st_reg <= irq_st_reg | irq_ev;
            if (wr_en && paddr == ADDR_IRQ_MK)
                irq_mk_reg <= pwdata[IRQ_W-1:0];
            irq <= |(irq_st_reg & irq_mk_reg);
        end
    end

    // ************************************************************
    // APB read path: no wait state, answer registered
    // ************************************************************
    logic [31:0] rd_mux;
    logic        hit;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        hit    = 1'b1;
        case (paddr)
            ADDR_CTRL:   rd_mux = 32'h0000_0000;
            ADDR_STATUS: rd_mux = {29'h0, core_halt, state_reg != BFR_IDLE, region_busy_flag};
            ADDR_LOCK:   rd_mux = {26'h0, boot_lock_reg, app_lock_reg, 2'h0};
            ADDR_IRQ_ST: rd_mux = {30'h0, irq_st_reg};
            ADDR_IRQ_MK: rd_mux = {30'h0, irq_mk_reg};
            ADDR_TADDR:  rd_mux = {{(32-AW){1'b0}}, prog_addr};
            default:     hit    = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : prdata;
        end
    end

endmodule // bfr_ctrl

// ===== test/bfr_ctrl_checker.sv
// Checker: concurrent assertions on the flash access controller ports
`timescale 1ns/10ps
module bfr_ctrl_checker
    import bfr_pkg::*;
#(
    parameter int AW       = 13,
    parameter int CONC_END = 13'h1c00,
    parameter int PROG_CYC = PROG_CYCLES
)(
    // Clock, reset and core side
    input wire logic          clk,
    input wire logic          rst_n,
    input wire logic          store_to_program_op,
    input wire logic          load_from_program_op,
    input wire logic [AW-1:0] pc_addr,
    input wire logic [AW-1:0] target_addr,
    input wire logic          core_halt,
    input wire logic          load_allowed,
    input wire logic          prog_start,
    input wire logic [AW-1:0] prog_addr,
    input wire logic          region_busy_flag,
    // APB
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [7:0]    paddr,
    input wire logic [31:0]   pwdata,
    input wire logic          pready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] halt_cnt;
    // Halt run length, judged on the cycle the halt drops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            halt_cnt <= 16'h0;
        else
            halt_cnt <= core_halt ? halt_cnt + 16'h1 : 16'h0;
    end
    sequence s_stall_start; prog_start && prog_addr >= CONC_END; endsequence
    sequence s_conc_start; prog_start && prog_addr < CONC_END; endsequence
    property p_app_refused; store_to_program_op && pc_addr < CONC_END |=> !prog_start; endproperty
    a_app_refused: assert property (p_app_refused) else $error("start from application code");
    property p_conc; s_conc_start |-> region_busy_flag && !core_halt; endproperty
    a_conc: assert property (p_conc) else $error("concurrent region op stalled core");
    property p_stall; s_stall_start |-> core_halt && !$rose(region_busy_flag); endproperty
    a_stall: assert property (p_stall) else $error("stalling region op without halt");
    property p_halt_len; $fell(core_halt) |-> halt_cnt == PROG_CYC; endproperty
    a_halt_len: assert property (p_halt_len) else $error("halt length wrong");
    property p_busy_hold;
        region_busy_flag && !(psel && penable && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_BUSY_CLR])
        |=> region_busy_flag;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy flag dropped by itself");
    property p_latch; prog_start |-> prog_addr == $past(target_addr); endproperty
    a_latch: assert property (p_latch) else $error("target address not latched");
    property p_addr_hold; !prog_start |-> $stable(prog_addr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("latched address moved");
    property p_load_block; region_busy_flag && load_from_program_op && target_addr < CONC_END |=> !load_allowed;
    endproperty
    a_load_block: assert property (p_load_block) else $error("busy region load allowed");
    property p_pready; psel && penable |-> pready; endproperty
    a_pready: assert property (p_pready) else $error("access cycle without ready");
endmodule // bfr_ctrl_checker

bind bfr_ctrl bfr_ctrl_checker #(.AW(AW), .CONC_END(CONC_END), .PROG_CYC(PROG_CYC)) u_checker (
    .clk(clk), .rst_n(rst_n), .store_to_program_op(store_to_program_op),
    .load_from_program_op(load_from_program_op), .pc_addr(pc_addr), .target_addr(target_addr),
    .core_halt(core_halt), .load_allowed(load_allowed), .prog_start(prog_start), .prog_addr(prog_addr),
    .region_busy_flag(region_busy_flag), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready));

// ===== test/bfr_core_model.sv
// Core model: issues program-memory store and load requests
`timescale 1ns/10ps
module bfr_core_model #(
    parameter int AW      = 13,
    parameter int CONC_END = 13'h1c00
)(
    // Clock and device status
    input wire logic          clk,
    input wire logic          core_halt,
    input wire logic          region_busy_flag,
    // Requests
    output logic              store_to_program_op,
    output logic              load_from_program_op,
    output logic [AW-1:0]     pc_addr,
    output logic [AW-1:0]     target_addr,
    // Wait limit used up
    output logic              wait_timeout
);
    initial
    begin
        store_to_program_op = 1'b0;
        load_from_program_op = 1'b0;
        pc_addr = '0;
        target_addr = '0;
        wait_timeout = 1'b0;
    end
    // No interrupt fetches are modelled, so no vector lands in the busy region
    task automatic issue(input logic st, input logic [AW-1:0] pc, input logic [AW-1:0] tgt);
        int i;
        i = 0;
        // A halted core issues nothing; busy region is left alone until cleared
        while ((core_halt === 1'b1 || (tgt < CONC_END && region_busy_flag === 1'b1)) && i < 100)
        begin
            @(posedge clk);
            i++;
        end
        if (i >= 100)
            wait_timeout <= 1'b1;
        store_to_program_op <= st;
        load_from_program_op <= !st;
        pc_addr <= pc;
        target_addr <= tgt;
        @(posedge clk);
        store_to_program_op <= 1'b0;
        load_from_program_op <= 1'b0;
        // Pointer reused at once for other work
        target_addr <= ~tgt;
    endtask
endmodule // bfr_core_model

// ===== test/tb_boot_flash_rww_control.sv
// Testbench: flash access controller driven over APB and a core model
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module tb_boot_flash_rww_control;
    import bfr_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, st_op, ld_op, halt, ld_ok, pstart, busy, irq, core_to;
    logic [2:0] fuses = 3'h0;
    logic [12:0] pc, tgt, paddr_l;
    int n_errors = 0, num_checks = 0, i;
    always #5 clk = ~clk;
    bfr_core_model core (.clk(clk), .core_halt(halt), .region_busy_flag(busy), .store_to_program_op(st_op),
        .load_from_program_op(ld_op), .pc_addr(pc), .target_addr(tgt), .wait_timeout(core_to));
    bfr_ctrl #(.PROG_CYC(8)) DUT (.clk(clk), .rst_n(rst_n), .boot_size_fuses(fuses),
        .store_to_program_op(st_op), .load_from_program_op(ld_op), .pc_addr(pc), .target_addr(tgt),
        .core_halt(halt), .load_allowed(ld_ok), .prog_start(pstart), .prog_addr(paddr_l),
        .region_busy_flag(busy), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
        begin
            n_errors++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never reassigns psel in this time step
        @(posedge clk);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b1, ADDR_IRQ_MK, 32'h3);
        apb(1'b0, ADDR_LOCK, 32'h0);
        `CHK("lock reset", 32'h3c, rd)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        core.issue(1'b1, 13'h0100, 13'h0100);
        repeat (2) @(posedge clk);
        `CHK("app start refused", 1'b1, irq)
        apb(1'b0, ADDR_IRQ_ST, 32'h0);
        `CHK("denied status", 32'h2, rd)
        core.issue(1'b1, 13'h1f80, 13'h0100);
        @(posedge clk);
        `CHK("conc start", 1'b1, pstart)
        `CHK("conc addr", 13'h0100, paddr_l)
        `CHK("conc no halt", 1'b0, halt)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status in op", 32'h3, rd)
        repeat (12) @(posedge clk);
        `CHK("busy held", 1'b1, busy)
        `CHK("done irq", 1'b1, irq)
        apb(1'b1, ADDR_CTRL, 32'h1);
        @(posedge clk);
        `CHK("busy cleared", 1'b0, busy)
        apb(1'b0, ADDR_IRQ_ST, 32'h0);
        `CHK("done status", 32'h1, rd)
        core.issue(1'b1, 13'h1f80, 13'h1d00);
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (halt !== 1'b1)
                break;
        end
        `CHK("halt cycles", 8, i)
        `CHK("stall no busy", 1'b0, busy)
        apb(1'b0, ADDR_TADDR, 32'h0);
        `CHK("latched addr", 32'h1d00, rd)
        apb(1'b1, ADDR_CTRL, 32'h3a);
        apb(1'b0, ADDR_LOCK, 32'h0);
        `CHK("app store lock", 32'h38, rd)
        apb(1'b0, ADDR_IRQ_ST, 32'h0);
        core.issue(1'b1, 13'h1f80, 13'h0200);
        repeat (2) @(posedge clk);
        apb(1'b0, ADDR_IRQ_ST, 32'h0);
        `CHK("app store denied", 32'h2, rd)
        apb(1'b1, ADDR_CTRL, 32'h3e);
        apb(1'b0, ADDR_LOCK, 32'h0);
        `CHK("no unlock by write", 32'h38, rd)
        apb(1'b1, ADDR_CTRL, 32'h100);
        apb(1'b1, ADDR_CTRL, 32'h0e);
        apb(1'b0, ADDR_LOCK, 32'h0);
        `CHK("boot lock only", 32'h0c, rd)
        apb(1'b1, ADDR_IRQ_MK, 32'h1);
        core.issue(1'b1, 13'h1f80, 13'h1d00);
        repeat (2) @(posedge clk);
        `CHK("masked denial", 1'b0, irq)
        apb(1'b0, ADDR_IRQ_ST, 32'h0);
        `CHK("boot store denied", 32'h2, rd)
        core.issue(1'b0, 13'h0100, 13'h1d00);
        @(posedge clk);
        `CHK("boot load blocked", 1'b0, ld_ok)
        core.issue(1'b0, 13'h1f80, 13'h0100);
        @(posedge clk);
        `CHK("app load allowed", 1'b1, ld_ok)
        apb(1'b1, ADDR_CTRL, 32'h100);
        apb(1'b0, ADDR_LOCK, 32'h0);
        `CHK("erase restores", 32'h3c, rd)
        // Second reset with the smallest boot size strapped
        fuses <= 3'h3;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        core.issue(1'b1, 13'h1f00, 13'h1d00);
        repeat (2) @(posedge clk);
        apb(1'b0, ADDR_IRQ_ST, 32'h0);
        `CHK("small boot denied", 32'h2, rd)
        core.issue(1'b1, 13'h1f80, 13'h1d00);
        @(posedge clk);
        `CHK("small boot start", 1'b1, pstart)
        `CHK("core wait", 1'b0, core_to)
        results();
    end
endmodule // tb_boot_flash_rww_control
